// ---- rtl/apms_pkg.sv ----
// Package of constants for the automatic power mode scheduler
//
// Contract
// - Automatic switching is on after reset; clearing its enable turns it off.
// - After reset the block starts in normal power mode.
// - Inactivity period is a programmed count of 512 ms steps.
// - Normal mode steps to reduced mode after a full quiet period.
// - Reduced steps to deepest mode after another quiet period, if enabled.
// - An event on an enabled channel in reduced or deepest mode returns to normal mode.
// - Normal mode converts all enabled channels each cycle at normal rate.
// - Reduced mode converts all enabled channels each cycle at slower rate.
// - Deepest mode converts channel 0 every cycle, others every nth cycle.
// - Divisor n comes from a three-bit setting field.
`default_nettype none
package apms_pkg;
   // ----------------------------------------
   // Modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      normal_power_mode,
      reduced_power_mode,
      deepest_power_mode
   } apms_mode_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned TIMER_STEP_MS   = 512;
   localparam int unsigned TIMER_STEP_CYC  = TIMER_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned RATE_STEP_MS    = 1;
   localparam int unsigned RATE_STEP_CYC   = RATE_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned NUM_CHAN        = 8;
   localparam logic        AUTO_EN_RST     = 1'b1;
   localparam logic [2:0]  DIV_FIELD_LSB   = 3'h0;
endpackage
`default_nettype wire

// ---- rtl/apms_scheduler.sv ----
// Automatic power mode scheduler with per-mode scan cycle generation
`timescale 1ns/1ps
`default_nettype none
module apms_scheduler
   import apms_pkg::*;
#(
   parameter int unsigned TICK_CYC  = TIMER_STEP_CYC,
   parameter int unsigned RATE_CYC  = RATE_STEP_CYC,
   parameter int unsigned NCH       = NUM_CHAN
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   // Configuration
   input  wire logic             auto_en_i,
   input  wire logic             deep_en_i,
   input  wire logic [2:0]       deep_div_i,
   input  wire logic [7:0]       quiet_steps_i,
   input  wire logic [7:0]       normal_rate_i,
   input  wire logic [7:0]       reduced_rate_i,
   input  wire logic [NCH-1:0]   chan_en_i,
   // Events from scan engine
   input  wire logic [NCH-1:0]   prox_evt_i,
   input  wire logic [NCH-1:0]   touch_evt_i,
   // Status and scan control
   output logic [1:0]            mode_o,
   output logic                  cycle_start_o,
   output logic [NCH-1:0]        scan_mask_o
);

   // ----------------------------------------
   // Event and timer decode
   // ----------------------------------------
   apms_mode_t           mode_r;
   apms_mode_t           mode_nxt;
   logic [31:0]          tick_cnt_r;
   logic [7:0]           step_cnt_r;
   logic [31:0]          rate_cnt_r;
   logic [7:0]           ms_cnt_r;
   logic [2:0]           deep_cyc_r;
   logic                 cycle_start_r;
   logic [NCH-1:0]       scan_mask_r;

   wire                  any_evt;
   wire                  tick_done;
   wire                  quiet_done;
   wire                  mode_chg;
   wire                  ms_done;
   wire [7:0]            rate_sel;
   wire                  cyc_fire;
   wire [2:0]            div_m1;
   wire                  deep_full;

   // Zero limit behaves as one; nine bits keep a full count from wrapping
   function automatic logic limit_hit(input logic [7:0] cnt, input logic [7:0] lim);
      logic [8:0] sum;
      sum = {1'b0, cnt} + 9'h001;
      return (sum >= {1'b0, lim});
   endfunction

   assign any_evt    = |((prox_evt_i | touch_evt_i) & chan_en_i);
   assign tick_done  = (tick_cnt_r == TICK_CYC - 1);
   // A zero period counts as one step so the timer can still expire
   assign quiet_done = tick_done && limit_hit(step_cnt_r, quiet_steps_i);
   assign mode_chg   = (mode_nxt != mode_r);

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         normal_power_mode: begin
            if (auto_en_i && !any_evt && quiet_done) begin
               mode_nxt = reduced_power_mode;
            end
         end
         reduced_power_mode: begin
            if (any_evt) begin
               mode_nxt = normal_power_mode;
            end else if (auto_en_i && deep_en_i && quiet_done) begin
               mode_nxt = deepest_power_mode;
            end
         end
         deepest_power_mode: begin
            if (any_evt) begin
               mode_nxt = normal_power_mode;
            end
         end
         default: begin
            mode_nxt = normal_power_mode;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_r <= normal_power_mode;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ----------------------------------------
   // Inactivity timer
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_cnt_r <= 32'h0;
         step_cnt_r <= 8'h00;
      end else if (any_evt || mode_chg) begin
         tick_cnt_r <= 32'h0;
         step_cnt_r <= 8'h00;
      end else if (tick_done) begin
         tick_cnt_r <= 32'h0;
         // Saturate so a held expiry does not wrap while switching is off
         if (step_cnt_r != 8'hff && !quiet_done) begin
            step_cnt_r <= step_cnt_r + 8'h01;
         end
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   // ----------------------------------------
   // Scan cycle pacing
   // ----------------------------------------
   // Rate byte is a period in ms steps; zero is treated as one step
   assign rate_sel  = (mode_r == normal_power_mode) ? normal_rate_i : reduced_rate_i;
   assign ms_done   = (rate_cnt_r == RATE_CYC - 1);
   assign cyc_fire  = ms_done && limit_hit(ms_cnt_r, rate_sel);
   assign div_m1    = (deep_div_i == 3'h0) ? 3'h0 : deep_div_i - 3'h1;
   assign deep_full = (deep_cyc_r == 3'h0);

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_cnt_r <= 32'h0;
         ms_cnt_r   <= 8'h00;
      end else if (mode_chg || ms_done) begin
         rate_cnt_r <= 32'h0;
         ms_cnt_r   <= (mode_chg || cyc_fire) ? 8'h00 : ms_cnt_r + 8'h01;
      end else begin
         rate_cnt_r <= rate_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         deep_cyc_r    <= 3'h0;
         cycle_start_r <= 1'b0;
         scan_mask_r   <= '0;
      end else begin
         cycle_start_r <= cyc_fire && !mode_chg;
         if (mode_chg) begin
            deep_cyc_r <= 3'h0;
         end else if (cyc_fire) begin
            if (mode_r == deepest_power_mode) begin
               // Channel 0 each cycle, the rest on the full cycle only
               scan_mask_r <= deep_full ? chan_en_i
                                        : (chan_en_i & {{(NCH-1){1'b0}}, 1'b1});
               deep_cyc_r  <= (deep_cyc_r >= div_m1) ? 3'h0 : deep_cyc_r + 3'h1;
            end else begin
               scan_mask_r <= chan_en_i;
            end
         end
      end
   end

   assign mode_o        = mode_r;
   assign cycle_start_o = cycle_start_r;
   assign scan_mask_o   = scan_mask_r;

   // ----------------------------------------
   // Checks: mode sequencing
   // ----------------------------------------
   chk_event_wakes: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (any_evt && mode_r != normal_power_mode) |=> (mode_r == normal_power_mode))
      else $error("event did not return to normal mode");

   chk_wake_target: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && any_evt) |-> (mode_nxt == normal_power_mode))
      else $error("event moved mode away from normal");

   chk_deep_stays: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == deepest_power_mode && !any_evt) |=> (mode_r == deepest_power_mode))
      else $error("deepest left without an event");

   chk_hold_disabled: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!auto_en_i && !any_evt) |=> $stable(mode_r))
      else $error("mode moved with switching off");

   chk_auto_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == normal_power_mode && !auto_en_i) |=> (mode_r == normal_power_mode))
      else $error("normal stepped down with switching off");

   chk_reduced_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == reduced_power_mode && !auto_en_i && !any_evt) |=> (mode_r == reduced_power_mode))
      else $error("reduced moved with switching off");

   chk_step_enabled: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && mode_nxt != normal_power_mode) |-> auto_en_i)
      else $error("step down while switching off");

   chk_step_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && mode_nxt != normal_power_mode) |-> !any_evt)
      else $error("step down despite an event");

   chk_normal_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == normal_power_mode && auto_en_i && !any_evt && quiet_done)
      |=> (mode_r == reduced_power_mode))
      else $error("normal did not step down");

   chk_reduced_entry: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && mode_nxt == reduced_power_mode) |-> (mode_r == normal_power_mode))
      else $error("reduced entered from deepest");

   chk_deep_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == reduced_power_mode && !deep_en_i) |=> (mode_r != deepest_power_mode))
      else $error("deepest entered while disabled");

   chk_deep_needs_en: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && mode_nxt == deepest_power_mode) |-> deep_en_i)
      else $error("deepest entered with deepest disabled");

   chk_deep_expiry: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == reduced_power_mode && auto_en_i && deep_en_i && !any_evt && quiet_done)
      |=> (mode_r == deepest_power_mode))
      else $error("reduced did not step to deepest");

   chk_no_skip: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r == normal_power_mode) |=> (mode_r != deepest_power_mode))
      else $error("normal jumped to deepest");

   chk_early_step: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_r != mode_nxt && mode_nxt != normal_power_mode) |-> tick_done)
      else $error("step down without timer expiry");

   chk_mode_legal: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_o != 2'h3))
      else $error("mode left its legal codes");

   // ----------------------------------------
   // Checks: inactivity timer
   // ----------------------------------------
   chk_timer_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (any_evt || mode_chg) |=> (step_cnt_r == 8'h00 && tick_cnt_r == 32'h0))
      else $error("timer not restarted");

   chk_tick_bound: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (tick_cnt_r < TICK_CYC))
      else $error("tick counter past its period");

   chk_tick_count: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!any_evt && !mode_chg && !tick_done)
      |=> (tick_cnt_r == $past(tick_cnt_r) + 32'h1))
      else $error("tick counter skipped");

   chk_step_count: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (tick_done && !any_evt && !mode_chg && !quiet_done)
      |=> (step_cnt_r == $past(step_cnt_r) + 8'h01))
      else $error("step counter missed a period");

   chk_step_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!tick_done && !any_evt && !mode_chg)
      |=> $stable(step_cnt_r))
      else $error("step counter moved between periods");

   // ----------------------------------------
   // Checks: scan pacing
   // ----------------------------------------
   // Mask and pulse move on the same edge, so a mask stands for its whole cycle
   chk_full_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cyc_fire && !mode_chg && mode_r != deepest_power_mode)
      |=> (scan_mask_o == $past(chan_en_i) && cycle_start_o))
      else $error("normal or reduced cycle not full");

   chk_pulse_single: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cycle_start_o && RATE_CYC > 32'h1) |=> !cycle_start_o)
      else $error("cycle start held past one cycle");

   chk_mask_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      !cycle_start_o |-> $stable(scan_mask_o))
      else $error("scan mask changed between cycles");

   chk_pace_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      mode_chg |=> (rate_cnt_r == 32'h0 && ms_cnt_r == 8'h00 && !cycle_start_o))
      else $error("pacing not restarted on mode change");

   chk_deep_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cyc_fire && !mode_chg && mode_r == deepest_power_mode && !deep_full)
      |=> (scan_mask_o[NCH-1:1] == '0))
      else $error("deepest partial cycle scanned others");

   chk_ch0_kept: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cyc_fire && !mode_chg)
      |=> (scan_mask_o[0] == $past(chan_en_i[0])))
      else $error("channel 0 left out of a cycle");

   chk_deep_full_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cyc_fire && !mode_chg && mode_r == deepest_power_mode && deep_full)
      |=> (scan_mask_o == $past(chan_en_i)))
      else $error("deepest full cycle not full");

   chk_deep_first: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (mode_chg && mode_nxt == deepest_power_mode) |=> deep_full)
      else $error("first deepest cycle not full");

   chk_deep_wrap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (cyc_fire && !mode_chg && mode_r == deepest_power_mode && deep_cyc_r >= div_m1)
      |=> deep_full)
      else $error("deepest divisor count did not wrap");

endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the automatic power mode scheduler
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import apms_pkg::*;
   localparam int unsigned TICK  = 20;
   localparam int unsigned RATE  = 5;
   localparam int unsigned LIMIT = 3000;
   typedef struct {logic au; logic de; logic [7:0] q; int w; logic [1:0] m;} apms_row_t;
   logic       ref_clk_i, sys_rst_i, auto_en_i, deep_en_i, cycle_start_o;
   logic [2:0] deep_div_i;
   logic [7:0] quiet_steps_i, normal_rate_i, reduced_rate_i, chan_en_i;
   logic [7:0] prox_evt_i, touch_evt_i, scan_mask_o;
   logic [1:0] mode_o;
   int         errors, comparisons, cycles, n;
   apms_row_t  rows [7] = '{'{1,1,2,35,0}, '{1,1,2,45,1}, '{1,1,2,90,2}, '{1,0,2,90,1},
                            '{1,1,1,15,0}, '{1,1,1,25,1}, '{0,1,1,50,0}};
   apms_scheduler #(.TICK_CYC(TICK), .RATE_CYC(RATE)) apms_scheduler_i (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .auto_en_i(auto_en_i),
      .deep_en_i(deep_en_i), .deep_div_i(deep_div_i), .quiet_steps_i(quiet_steps_i),
      .normal_rate_i(normal_rate_i), .reduced_rate_i(reduced_rate_i),
      .chan_en_i(chan_en_i), .prox_evt_i(prox_evt_i), .touch_evt_i(touch_evt_i),
      .mode_o(mode_o), .cycle_start_o(cycle_start_o), .scan_mask_o(scan_mask_o));
   // ----------------------------------------
   // Checking and report
   // ----------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_int(input string nm, input int e, input int g);
      comparisons++;
      if (g != e) begin
         errors++;
         $display("mismatch %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Stimulus helpers, all on falling edges
   // ----------------------------------------
   task automatic evt(input logic [7:0] p, input logic [7:0] t);
      prox_evt_i = p;
      touch_evt_i = t;
      @(negedge ref_clk_i);
      prox_evt_i = 8'h00;
      touch_evt_i = 8'h00;
      @(negedge ref_clk_i);
   endtask
   // Bounded wait so a missing pulse cannot hang the run
   task automatic next_start(output int c);
      c = 0;
      do begin
         @(negedge ref_clk_i);
         c++;
      end while (cycle_start_o !== 1'b1 && c < 200);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         final_report();
      end
   end
   initial begin
      {sys_rst_i, auto_en_i, deep_en_i} = 3'h7;
      {prox_evt_i, touch_evt_i} = 16'h0000;
      deep_div_i = 3'h4;
      quiet_steps_i = 8'h02;
      normal_rate_i = 8'h01;
      reduced_rate_i = 8'h02;
      chan_en_i = 8'h0f;
      repeat (6) @(negedge ref_clk_i);
      chk8("reset mode", 8'h00, {6'h00, mode_o});
      chk8("reset mask", 8'h00, scan_mask_o);
      sys_rst_i = 1'b0;
      // Wake first, so every row starts from normal with a fresh timer
      foreach (rows[i]) begin
         auto_en_i = rows[i].au;
         deep_en_i = rows[i].de;
         quiet_steps_i = rows[i].q;
         if (i % 2) evt(8'h01 << (i % 4), 8'h00);
         else evt(8'h00, 8'h01 << (i % 4));
         chk8("wake mode", 8'h00, {6'h00, mode_o});
         repeat (rows[i].w) @(negedge ref_clk_i);
         chk8("row mode", {6'h00, rows[i].m}, {6'h00, mode_o});
      end
      auto_en_i = 1'b1;
      deep_en_i = 1'b0;
      evt(8'h00, 8'h08);
      next_start(n);
      next_start(n);
      chk_int("normal period", 1 * RATE, n);
      chk8("normal mask", 8'h0f, scan_mask_o);
      @(negedge ref_clk_i);
      chk8("pulse width", 8'h00, {7'h00, cycle_start_o});
      repeat (25) @(negedge ref_clk_i);
      chk8("reduced mode", 8'h01, {6'h00, mode_o});
      next_start(n);
      next_start(n);
      chk_int("reduced period", 2 * RATE, n);
      chk8("reduced mask", 8'h0f, scan_mask_o);
      deep_en_i = 1'b1;
      repeat (45) @(negedge ref_clk_i);
      chk8("deep mode", 8'h02, {6'h00, mode_o});
      // Sync on a full scan, then n-1 scans of channel 0 only
      for (int k = 0; k < 8 && scan_mask_o !== 8'h0f; k++) next_start(n);
      for (int j = 1; j <= 4; j++) begin
         next_start(n);
         chk8("deep mask", (j == 4) ? 8'h0f : 8'h01, scan_mask_o);
      end
      evt(8'h80, 8'h00);
      chk8("masked event", 8'h02, {6'h00, mode_o});
      // Divisor one: after at most one partial scan every scan is full
      deep_div_i = 3'h1;
      next_start(n);
      for (int j = 0; j < 2; j++) begin
         next_start(n);
         chk8("deep div one", 8'h0f, scan_mask_o);
      end
      sys_rst_i = 1'b1;
      @(negedge ref_clk_i);
      chk8("rerun mode", 8'h00, {6'h00, mode_o});
      chk8("rerun start", 8'h00, {7'h00, cycle_start_o});
      sys_rst_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      chk8("release mode", 8'h00, {6'h00, mode_o});
      chk8("release mask", 8'h00, scan_mask_o);
      chk8("release start", 8'h00, {7'h00, cycle_start_o});
      final_report();
   end
endmodule
`default_nettype wire
